//--- rtl/exec_pkg.sv
// Constants for the shadow, power-save, relative-call and repeat execution block
package exec_pkg;
    localparam int          WORD_W         = 16;
    localparam int          PC_W           = 23;
    localparam int          COUNT_W        = 14;
    localparam int          NFLAG          = 5;
    // Opcode patterns, 24-bit instruction words
    localparam logic [23:0] OPC_PUSH_SHADOW = 24'hfea000;
    localparam logic [23:0] OPC_POP_SHADOW  = 24'hfe8000;
    localparam logic [22:0] OPC_POWER_SAVE  = 23'h7f2000; // bits 23:1
    localparam logic [7:0]  OPC_CALL_LIT    = 8'h07;
    localparam logic [19:0] OPC_CALL_REG    = 20'h01200;  // bits 23:4
    localparam logic [9:0]  OPC_LOOP_LIT    = 10'h024;    // bits 23:14
    localparam logic [19:0] OPC_LOOP_REG    = 20'h09800;  // bits 23:4
    localparam logic [23:0] OPC_NOP         = 24'h000000;
    // Reset control register flag positions
    localparam int          RST_CTRL_TIMEOUT_BIT = 4;
    localparam int          RST_CTRL_DEEP_BIT    = 3;
    localparam int          RST_CTRL_HALT_BIT    = 2;
    localparam logic [7:0]  RST_CTRL_RESET       = 8'h00;
    localparam logic [15:0] SP_RESET         = 16'h0800;
    localparam logic [22:0] PC_STEP          = 23'h000002;
    localparam logic [15:0] SP_STEP          = 16'h0002;
    localparam logic [22:0] PC_RESET         = 23'h000000;
    // Flag vector order: {digit_carry, negative, overflow, zero, carry}
endpackage

//--- rtl/shadow_if.sv
// Interface carrying working registers and flags between core and shadow bank
`timescale 1ns/1ns
interface shadow_if;
    logic [3:0][15:0] work_regs;
    logic [4:0]       work_flags;
    logic [3:0][15:0] saved_regs;
    logic [4:0]       saved_flags;
    logic             save_req;
    modport core  (output work_regs, output work_flags, output save_req,
                   input saved_regs, input saved_flags);
    modport bank  (input work_regs, input work_flags, input save_req,
                   output saved_regs, output saved_flags);
endinterface

//--- rtl/shadow_bank.sv
// One-level shadow bank for working registers zero to three and five flags
`timescale 1ns/1ns
module shadow_bank (
    input  wire logic clock_i,
    input  wire logic reset_n_i,
    shadow_if.bank    sh
);
    logic [3:0][15:0] regs_r;
    logic [4:0]       flags_r;

    // Only the save strobe writes; no other path reaches this storage
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            regs_r  <= '0;
            flags_r <= '0;
        end else if (sh.save_req) begin
            regs_r  <= sh.work_regs;
            flags_r <= sh.work_flags;
        end
    end

    assign sh.saved_regs  = regs_r;
    assign sh.saved_flags = flags_r;

    property p_save_copies;
        @(posedge clock_i) disable iff (!reset_n_i)
        sh.save_req |=> (regs_r == $past(sh.work_regs) && flags_r == $past(sh.work_flags));
    endproperty
    a_save_copies: assert property (p_save_copies) else $error("save missed");

    property p_hold_saved;
        @(posedge clock_i) disable iff (!reset_n_i)
        !sh.save_req |=> $stable(regs_r) && $stable(flags_r);
    endproperty
    a_hold_saved: assert property (p_hold_saved) else $error("bank changed");
endmodule

//--- rtl/exec_core.sv
// Execution core for shadow save/restore, power save, relative calls and repeat loops
// Function
// - Shadow save copies working registers zero to three and five flags.
// - Shadow bank is one level, reachable only by save and restore.
// - Shadow restore copies saved values back, leaving the bank unchanged.
// - Power save clears watchdog counter, both prescalers, and flags 4,3,2.
// - Mode bit 0 stops CPU, peripheral and oscillator clocks.
// - Mode bit 1 stops only the CPU clock.
// - Interrupt, reset or watchdog time-out wakes either mode.
// - Wake sets the matching halt flag and restores the clocks.
// - Watchdog time-out wake sets the timeout flag.
// - Literal call adds doubled signed 16-bit offset to return address.
// - Calls push return address low word then high bits, SP plus two each.
// - Literal call decoded from upper byte 07, one word, two cycles.
// - Register call takes doubled signed offset from selected working register.
// - Register call decoded from fixed pattern with register in low nibble.
// - Literal loop loads remaining count with 14-bit literal.
// - Register loop loads remaining count from low 14 register bits.
// - Register loop decoded from fixed pattern with low register nibble.
// - Loop target is fetched once and held for every iteration.
// - Count decrements per target run; at zero target runs once more.
// - Zero count acts as no-operation without setting the active flag.
// - Loop and target stay interruptible mid-loop.
`timescale 1ns/1ns
module exec_core (
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    input  wire logic [23:0] instr_i,
    input  wire logic        instr_valid_i,
    input  wire logic        irq_i,
    input  wire logic        watchdog_timeout_i,
    output logic             fetch_hold_o,
    output logic [22:0]      pc_o,
    output logic [15:0]      stack_pointer_reg_o,
    output logic [15:0]      stack_wdata_o,
    output logic [15:0]      stack_waddr_o,
    output logic             stack_we_o,
    output logic [3:0][15:0] work_regs_o,
    output logic [4:0]       work_flags_o,
    output logic [13:0]      loop_remaining_count_o,
    output logic             loop_active_flag_o,
    output logic [7:0]       reset_control_reg_o,
    output logic             watchdog_clear_o,
    output logic             cpu_clock_en_o,
    output logic             periph_clock_en_o,
    output logic             osc_en_o,
    output logic             irq_take_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_CALL2 = 2'b01,
        ST_HALT  = 2'b10,
        ST_DEEP  = 2'b11
    } state_type;

    state_type        state_r;
    state_type        state_nxt;
    logic [22:0]      pc_r;
    logic [22:0]      ret_r;
    logic [22:0]      target_r;
    logic [15:0]      sp_r;
    logic [15:0]      wdata_r;
    logic [15:0]      waddr_r;
    logic             we_r;
    logic [3:0][15:0] wregs_r;
    logic [4:0]       flags_r;
    logic [13:0]      count_r;
    logic             active_r;
    logic [23:0]      ir_r;
    logic             ir_full_r;
    logic             squash_r;
    logic [7:0]       rst_ctrl_r;
    logic             wclr_r;

    shadow_if sh ();

    shadow_bank u_shadow (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .sh        (sh)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire        run_w       = (state_r == ST_RUN);
    wire [23:0] op_w        = squash_r ? exec_pkg::OPC_NOP : ir_r;
    wire        exec_w      = run_w && ir_full_r && !irq_i;
    wire        is_push_w   = exec_w && (op_w == exec_pkg::OPC_PUSH_SHADOW);
    wire        is_pop_w    = exec_w && (op_w == exec_pkg::OPC_POP_SHADOW);
    wire        is_pwr_w    = exec_w && (op_w[23:1] == exec_pkg::OPC_POWER_SAVE);
    wire        is_clit_w   = exec_w && (op_w[23:16] == exec_pkg::OPC_CALL_LIT);
    wire        is_creg_w   = exec_w && (op_w[23:4] == exec_pkg::OPC_CALL_REG);
    wire        is_llit_w   = exec_w && !active_r
                              && (op_w[23:14] == exec_pkg::OPC_LOOP_LIT);
    wire        is_lreg_w   = exec_w && !active_r
                              && (op_w[23:4] == exec_pkg::OPC_LOOP_REG);
    wire        is_call_w   = is_clit_w || is_creg_w;
    wire [3:0]  sel_w       = op_w[3:0];
    // Registers outside zero..three are not modelled here; they read as zero
    wire [15:0] selreg_w    = (sel_w < 4'h4) ? wregs_r[sel_w[1:0]] : 16'h0000;
    wire [15:0] offs_w      = is_clit_w ? op_w[15:0] : selreg_w;
    wire [22:0] offs2_w     = {{6{offs_w[15]}}, offs_w, 1'b0};
    wire [22:0] ret_w       = pc_r + exec_pkg::PC_STEP;
    wire [13:0] lcount_w    = is_llit_w ? op_w[13:0] : selreg_w[13:0];
    wire        loop_load_w = is_llit_w || is_lreg_w;
    wire        loop_step_w = exec_w && active_r;
    wire        wake_w      = irq_i || watchdog_timeout_i;

    assign sh.work_regs  = wregs_r;
    assign sh.work_flags = flags_r;
    assign sh.save_req   = is_push_w;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (is_call_w) begin
                    state_nxt = ST_CALL2;
                end else if (is_pwr_w) begin
                    state_nxt = op_w[0] ? ST_HALT : ST_DEEP;
                end
            end
            ST_CALL2: state_nxt = ST_RUN;
            ST_HALT:  if (wake_w) state_nxt = ST_RUN;
            ST_DEEP:  if (wake_w) state_nxt = ST_RUN;
            default:  state_nxt = ST_RUN;
        endcase
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Instruction register and loop
    // ------------------------------------------------------------
    // The register is refilled only when no loop holds it
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ir_r      <= exec_pkg::OPC_NOP;
            ir_full_r <= 1'b0;
            squash_r  <= 1'b0;
        end else if (run_w && !(active_r && ir_full_r)) begin
            ir_r      <= instr_i;
            ir_full_r <= instr_valid_i;
            squash_r  <= is_call_w;
        end else if (state_r == ST_CALL2) begin
            // Slot word stays squashed into the first running cycle after the call
            squash_r  <= 1'b1;
        end else if (loop_step_w && count_r == 14'h0000) begin
            ir_full_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_r  <= '0;
            active_r <= 1'b0;
        end else if (loop_load_w) begin
            count_r  <= lcount_w;
            active_r <= (lcount_w != 14'h0000);
        end else if (loop_step_w) begin
            if (count_r == 14'h0000) begin
                active_r <= 1'b0;
            end else begin
                count_r <= count_r - 14'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Program counter, stack and registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pc_r     <= exec_pkg::PC_RESET;
            ret_r    <= exec_pkg::PC_RESET;
            target_r <= exec_pkg::PC_RESET;
            sp_r     <= exec_pkg::SP_RESET;
            wdata_r  <= '0;
            waddr_r  <= '0;
            we_r     <= 1'b0;
        end else begin
            we_r <= 1'b0;
            if (is_call_w) begin
                ret_r    <= ret_w;
                target_r <= ret_w + offs2_w;
                wdata_r  <= ret_w[15:0];
                waddr_r  <= sp_r;
                we_r     <= 1'b1;
                sp_r     <= sp_r + exec_pkg::SP_STEP;
            end else if (state_r == ST_CALL2) begin
                wdata_r  <= {9'h000, ret_r[22:16]};
                waddr_r  <= sp_r;
                we_r     <= 1'b1;
                sp_r     <= sp_r + exec_pkg::SP_STEP;
                pc_r     <= target_r;
            end else if (exec_w && !squash_r && !(active_r && count_r != 14'h0000)) begin
                pc_r <= ret_w;
            end
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wregs_r <= '0;
            flags_r <= '0;
        end else if (is_pop_w) begin
            wregs_r <= sh.saved_regs;
            flags_r <= sh.saved_flags;
        end
    end

    // ------------------------------------------------------------
    // Power save and reset control flags
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_ctrl_r <= exec_pkg::RST_CTRL_RESET;
            wclr_r     <= 1'b0;
        end else begin
            wclr_r <= is_pwr_w;
            if (is_pwr_w) begin
                rst_ctrl_r[exec_pkg::RST_CTRL_TIMEOUT_BIT] <= 1'b0;
                rst_ctrl_r[exec_pkg::RST_CTRL_DEEP_BIT]    <= 1'b0;
                rst_ctrl_r[exec_pkg::RST_CTRL_HALT_BIT]    <= 1'b0;
            end
            if (state_r == ST_HALT && wake_w) begin
                rst_ctrl_r[exec_pkg::RST_CTRL_HALT_BIT] <= 1'b1;
            end
            if (state_r == ST_DEEP && wake_w) begin
                rst_ctrl_r[exec_pkg::RST_CTRL_DEEP_BIT] <= 1'b1;
            end
            if (!run_w && state_r != ST_CALL2 && watchdog_timeout_i) begin
                rst_ctrl_r[exec_pkg::RST_CTRL_TIMEOUT_BIT] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign fetch_hold_o           = !run_w || (active_r && ir_full_r);
    assign pc_o                   = pc_r;
    assign stack_pointer_reg_o    = sp_r;
    assign stack_wdata_o          = wdata_r;
    assign stack_waddr_o          = waddr_r;
    assign stack_we_o             = we_r;
    assign work_regs_o            = wregs_r;
    assign work_flags_o           = flags_r;
    assign loop_remaining_count_o = count_r;
    assign loop_active_flag_o     = active_r;
    assign reset_control_reg_o    = rst_ctrl_r;
    assign watchdog_clear_o       = wclr_r;
    assign cpu_clock_en_o         = (state_r != ST_HALT) && (state_r != ST_DEEP);
    assign periph_clock_en_o      = (state_r != ST_DEEP);
    assign osc_en_o               = (state_r != ST_DEEP);
    // An interrupt is taken even inside a loop; the loop state is kept
    assign irq_take_o             = irq_i && (run_w || wake_w);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_call_first;
        we_r && stack_wdata_o == $past(ret_w[15:0]);
    endsequence
    sequence s_call_second;
        we_r && stack_wdata_o[6:0] == ret_r[22:16];
    endsequence

    property p_call_push;
        @(posedge clock_i) disable iff (!reset_n_i)
        is_call_w |=> s_call_first ##1 s_call_second;
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push order wrong");

    property p_call_target;
        @(posedge clock_i) disable iff (!reset_n_i)
        is_call_w |=> ##1 pc_r == $past(ret_w, 2) + $past(offs2_w, 2);
    endproperty
    a_call_target: assert property (p_call_target) else $error("call target wrong");

    property p_call_slot;
        @(posedge clock_i) disable iff (!reset_n_i)
        is_call_w |=> ##1 op_w == exec_pkg::OPC_NOP;
    endproperty
    a_call_slot: assert property (p_call_slot) else $error("call slot word ran");

    property p_call_sp;
        @(posedge clock_i) disable iff (!reset_n_i)
        is_call_w |=> ##1 sp_r == $past(sp_r, 2) + 16'h0004;
    endproperty
    a_call_sp: assert property (p_call_sp) else $error("stack pointer not advanced");

    property p_pwr_clear;
        @(posedge clock_i) disable iff (!reset_n_i)
        is_pwr_w |=> watchdog_clear_o && rst_ctrl_r[4:2] == 3'b000;
    endproperty
    a_pwr_clear: assert property (p_pwr_clear) else $error("power save did not clear");

    property p_deep_clocks;
        @(posedge clock_i) disable iff (!reset_n_i)
        is_pwr_w && !op_w[0] |=> !cpu_clock_en_o && !periph_clock_en_o && !osc_en_o;
    endproperty
    a_deep_clocks: assert property (p_deep_clocks) else $error("deep halt clocks run");

    property p_halt_clocks;
        @(posedge clock_i) disable iff (!reset_n_i)
        is_pwr_w && op_w[0] |=> !cpu_clock_en_o && periph_clock_en_o && osc_en_o;
    endproperty
    a_halt_clocks: assert property (p_halt_clocks) else $error("halt clocks wrong");

    property p_halt_wake;
        @(posedge clock_i) disable iff (!reset_n_i)
        state_r == ST_HALT && irq_i |=> cpu_clock_en_o && rst_ctrl_r[2];
    endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("halt wake wrong");

    property p_wdt_wake;
        @(posedge clock_i) disable iff (!reset_n_i)
        state_r == ST_DEEP && watchdog_timeout_i |=> rst_ctrl_r[4] && rst_ctrl_r[3];
    endproperty
    a_wdt_wake: assert property (p_wdt_wake) else $error("timeout flag not set");

    property p_loop_zero;
        @(posedge clock_i) disable iff (!reset_n_i)
        loop_load_w && lcount_w == 14'h0000 |=> !active_r;
    endproperty
    a_loop_zero: assert property (p_loop_zero) else $error("zero loop set active");

    property p_loop_dec;
        @(posedge clock_i) disable iff (!reset_n_i)
        loop_step_w && count_r != 14'h0000 |=> count_r == $past(count_r) - 14'h0001;
    endproperty
    a_loop_dec: assert property (p_loop_dec) else $error("loop count not decremented");

    property p_restore;
        @(posedge clock_i) disable iff (!reset_n_i)
        is_pop_w |=> wregs_r == $past(sh.saved_regs) && flags_r == $past(sh.saved_flags);
    endproperty
    a_restore: assert property (p_restore) else $error("restore wrong");
endmodule

//--- verification/prog_mem_model.sv
// Program memory model feeding the instruction stream of the execution core
`timescale 1ns/1ns
module prog_mem_model (
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    input  wire logic        fetch_hold_i,
    output logic      [23:0] instr_o,
    output logic             instr_valid_o
);
    logic [23:0] q[$];
    logic        hold;

    initial begin
        instr_o       = 24'h000000;
        instr_valid_o = 1'b0;
    end

    task automatic push(input logic [23:0] w);
        q.push_back(w);
    endtask

    // ------------------------------------------------------------
    // Word presentation
    // ------------------------------------------------------------
    // An empty stream inverts the shown word every cycle with valid low, so a stale opcode never passes
    always @(posedge clock_i) begin
        hold = fetch_hold_i | ~reset_n_i;
        #1;
        if (!hold && instr_valid_o) begin
            void'(q.pop_front());
        end
        if (q.size() != 0) begin
            instr_o       = q[0];
            instr_valid_o = 1'b1;
        end else begin
            instr_o       = ~instr_o;
            instr_valid_o = 1'b0;
        end
    end
endmodule

//--- verification/tb_shadow_power_call_loop_exec.sv
// Self-checking bench for the execution core against a behavioural reference
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_shadow_power_call_loop_exec;
    logic             clock_i   = 1'b0;
    logic             reset_n_i = 1'b0;
    logic             irq_i     = 1'b0;
    logic             wd_to     = 1'b0;
    logic [23:0]      instr;
    logic             instr_valid, fetch_hold, stack_we, wd_clr, loop_act;
    logic             cpu_en, per_en, osc_en, irq_take;
    logic [22:0]      pc, pcm;
    logic [15:0]      sp, stack_wdata, stack_waddr, spm;
    logic [3:0][15:0] work_regs;
    logic [4:0]       work_flags;
    logic [13:0]      loop_cnt, peak;
    logic [7:0]       rctl, rcm;
    logic [31:0]      lfsr_r = 32'hf1f5158e;
    logic [31:0]      pushes[$];
    bit               wdclr_seen, act_seen, take_seen;
    int               fail_count, compares, i;

    always #20 clock_i = ~clock_i;

    prog_mem_model PM (.clock_i(clock_i), .reset_n_i(reset_n_i), .fetch_hold_i(fetch_hold),
        .instr_o(instr), .instr_valid_o(instr_valid));

    exec_core DUT (.clock_i(clock_i), .reset_n_i(reset_n_i), .instr_i(instr),
        .instr_valid_i(instr_valid), .irq_i(irq_i), .watchdog_timeout_i(wd_to),
        .fetch_hold_o(fetch_hold), .pc_o(pc), .stack_pointer_reg_o(sp),
        .stack_wdata_o(stack_wdata), .stack_waddr_o(stack_waddr), .stack_we_o(stack_we),
        .work_regs_o(work_regs), .work_flags_o(work_flags), .loop_remaining_count_o(loop_cnt),
        .loop_active_flag_o(loop_act), .reset_control_reg_o(rctl), .watchdog_clear_o(wd_clr),
        .cpu_clock_en_o(cpu_en), .periph_clock_en_o(per_en), .osc_en_o(osc_en),
        .irq_take_o(irq_take));

    // ------------------------------------------------------------
    // Output monitor
    // ------------------------------------------------------------
    always @(posedge clock_i) begin
        if (stack_we === 1'b1) pushes.push_back({stack_waddr, stack_wdata});
        if (wd_clr === 1'b1) wdclr_seen = 1'b1;
        if (loop_act === 1'b1) act_seen = 1'b1;
        if (irq_take === 1'b1) take_seen = 1'b1;
        if (loop_cnt > peak) peak = loop_cnt;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic test_done;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic issue(input logic [23:0] w);
        pushes.delete();
        {wdclr_seen, act_seen, take_seen, peak} = '0;
        PM.push(w);
    endtask

    // Halted cores keep fetch held, so halt_ok drops that from the idle test
    task automatic settle(input bit halt_ok);
        int n;
        for (n = 0; n < 20000; n++) begin
            if (PM.q.size() == 0 && (halt_ok || fetch_hold === 1'b0) && loop_act !== 1'b1) break;
            tick(1);
        end
        if (n == 20000) begin
            fail_count++;
            test_done();
        end
        tick(3);
    endtask

    task automatic check_call(input logic [15:0] off);
        logic [22:0] ret;
        ret = pcm + 23'h000002;
        `CHK(pushes.size(), 2)
        if (pushes.size() == 2) begin
            `CHK(pushes[0], {spm, ret[15:0]})
            `CHK(pushes[1], {spm + 16'h0002, 9'h000, ret[22:16]})
        end
        spm = spm + 16'h0004;
        pcm = ret + {{6{off[15]}}, off, 1'b0};
        `CHK(sp, spm)
        `CHK(pc, pcm)
        `CHK(cpu_en, 1'b1)
        `CHK(wdclr_seen, 1'b0)
    endtask

    task automatic run_loop(input logic [23:0] w, input int n, input bit pulse);
        issue(w);
        PM.push(exec_pkg::OPC_NOP);
        if (pulse) begin
            tick(30);
            irq_i = 1'b1;
            tick(1);
            irq_i = 1'b0;
        end
        settle(1'b0);
        `CHK(peak, 14'(n))
        `CHK(act_seen, n != 0)
        `CHK(loop_cnt, 14'h0000)
        pcm = pcm + 23'h000004;
        `CHK(pc, pcm)
        if (pulse) `CHK(take_seen, 1'b1)
    endtask

    initial begin
        pcm = exec_pkg::PC_RESET;
        spm = exec_pkg::SP_RESET;
        tick(4);
        reset_n_i = 1'b1;
        tick(1);
        `CHK(sp, spm)
        `CHK(rctl, exec_pkg::RST_CTRL_RESET)
        // The call slot word is a power save that must never run
        issue({exec_pkg::OPC_CALL_LIT, 16'h7fff});
        PM.push({exec_pkg::OPC_POWER_SAVE, 1'b0});
        settle(1'b0);
        check_call(16'h7fff);
        for (i = 0; i < 4; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            issue({exec_pkg::OPC_CALL_LIT, (i == 0) ? 16'h8000 : lfsr_r[15:0]});
            settle(1'b0);
            check_call((i == 0) ? 16'h8000 : lfsr_r[15:0]);
        end
        issue({exec_pkg::OPC_CALL_REG, lfsr_r[19:16]});
        settle(1'b0);
        check_call(16'h0000);
        run_loop({exec_pkg::OPC_LOOP_LIT, 14'h0000}, 0, 1'b0);
        run_loop({exec_pkg::OPC_LOOP_LIT, 14'h3fff}, 16383, 1'b1);
        run_loop({exec_pkg::OPC_LOOP_LIT, 9'h000, lfsr_r[4:0]}, lfsr_r[4:0], 1'b0);
        run_loop({exec_pkg::OPC_LOOP_REG, lfsr_r[23:20]}, 0, 1'b0);
        issue(exec_pkg::OPC_PUSH_SHADOW);
        PM.push(exec_pkg::OPC_POP_SHADOW);
        settle(1'b0);
        `CHK(work_regs, 64'h0)
        `CHK(work_flags, 5'h00)
        pcm = pcm + 23'h000004;
        `CHK(pc, pcm)
        for (i = 0; i < 4; i++) begin
            issue({exec_pkg::OPC_POWER_SAVE, i[0]});
            settle(1'b1);
            `CHK({cpu_en, per_en, osc_en}, {1'b0, i[0], i[0]})
            `CHK(rctl[4:2], 3'h0)
            `CHK(wdclr_seen, 1'b1)
            if (i[1]) wd_to = 1'b1;
            else irq_i = 1'b1;
            tick(1);
            wd_to = 1'b0;
            irq_i = 1'b0;
            tick(3);
            rcm = 8'h00;
            rcm[i[0] ? 2 : 3] = 1'b1;
            rcm[4] = i[1];
            `CHK(rctl, rcm)
            `CHK({cpu_en, per_en, osc_en}, 3'h7)
            pcm = pcm + 23'h000002;
            `CHK(pc, pcm)
        end
        test_done();
    end
endmodule
